//--- inc/fco_defines.svh
`ifndef FCO_DEFINES_SVH
`define FCO_DEFINES_SVH
// ==========================================
// Widths and codes
`define FCO_DATA_W        7
`define FCO_THERM_W       128
`define FCO_CODE_ZERO     7'h00
`define FCO_CODE_TOP      7'h7f
`define FCO_FIFO_DEPTH    8
// ==========================================
// Clock shaping (link clock made from clk by enables)
`define FCO_CLK_PERIOD_NS 8
`define FCO_SAMPLE_NS     12
// Low interval: least time, rounded up, at least one cycle
`define FCO_LOW_CYC       ((`FCO_SAMPLE_NS + `FCO_CLK_PERIOD_NS - 1) / `FCO_CLK_PERIOD_NS)
`define FCO_HIGH_CYC      2
`define FCO_CNT_W         4
`endif

//--- inc/fco_pkg.sv
package fco_pkg;
   // Phase of the conversion clock
   typedef enum logic [1:0] {
      FCO_AUTOZERO = 2'b01,
      FCO_SAMPLE   = 2'b10
   } fco_phase_t;
   // Sample word as captured by the far end
   typedef struct packed {
      logic       over_range;
      logic [6:0] data;
   } fco_word_t;
endpackage : fco_pkg

//--- inc/fco_if.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Pins between converter and capturing logic
interface fco_if;
   logic       conv_clk;            // Conversion clock level
   logic       data_bits_select;    // First select
   logic       output_group_select; // Second select
   logic [6:0] data_o;              // Data bits driven value
   logic       data_oe;             // Data bits enable
   logic       ovr_o;               // Over-range driven value
   logic       ovr_oe;              // Over-range enable
   modport dev  (input conv_clk, data_bits_select, output_group_select,
                 output data_o, data_oe, ovr_o, ovr_oe);
   modport host (output conv_clk, data_bits_select, output_group_select,
                 input data_o, data_oe, ovr_o, ovr_oe);
endinterface : fco_if
`default_nettype wire

//--- design/fco_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "fco_defines.svh"
// ==========================================
// Synchronous FIFO with valid/ready both sides
module fco_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `FCO_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];   // Storage
   logic [AW-1:0]    wr_ff, nxt_wr;    // Write pointer
   logic [AW-1:0]    rd_ff, nxt_rd;    // Read pointer
   logic [AW:0]      cnt_ff, nxt_cnt;  // Fill level
   logic             push, pop;        // Accepted moves

   // Handshake and pointer update
   always_comb begin
      // Room while the fill level is below the depth
      in_ready  = (cnt_ff != (AW+1)'(DEPTH));
      out_valid = (cnt_ff != '0);
      out_data  = mem_ff[rd_ff];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      nxt_wr    = push ? AW'(wr_ff + 1'b1) : wr_ff;
      nxt_rd    = pop ? AW'(rd_ff + 1'b1) : rd_ff;
      nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
   end

   // Pointer registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end
endmodule : fco_fifo
`default_nettype wire

//--- design/fco_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "fco_defines.svh"
// ==========================================
// Converter digital side: phase tracking, latching, encoding, outputs
module fco_device (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst,
   // Pins to capturing logic
   fco_if.dev                  pins,
   // Comparator decisions (thermometer, bit i = input above step i)
   input  wire logic [127:0]   cmp_therm,
   // Phase shown to the analog side
   output logic                autozero_on,
   output logic                sample_on
);
   import fco_pkg::*;

   // ==========================================
   // Declarations
   // Phase and indicator state
   fco_phase_t   phase_ff, nxt_phase;  // Phase seen at the last edge
   logic         az_ff, nxt_az;        // Auto-zero indicator
   logic         sm_ff, nxt_sm;        // Sampling indicator
   // Comparator latch state
   logic [127:0] latch_ff, nxt_latch;  // Comparator latches
   // Output latch state
   logic [6:0]   code_ff, nxt_code;    // Output latch data
   logic         ovr_ff, nxt_ovr;      // Output latch over-range
   // Output enable state
   logic         doe_ff, nxt_doe;      // Data enable
   logic         ooe_ff, nxt_ooe;      // Over-range enable
   // Helpers
   logic         cc_high;              // Conversion clock level this cycle
   logic         rise;                 // Conversion clock rising
   logic [7:0]   acc [129];            // Running sums of the ones counter
   logic [7:0]   ones;                 // Count of tripped comparators
   logic [6:0]   enc_code;             // Encoder data result
   logic         enc_ovr;              // Encoder over-range result

   // ==========================================
   // Phase tracking
   // The conversion clock comes in as a level on the clk grid. Its
   // value at each edge picks the phase; the phase of the previous
   // edge is kept so that a low-to-high step can be told apart from
   // a level that merely stays high.
   assign cc_high = pins.conv_clk;

   // Next phase and indicator values
   always_comb begin
      nxt_phase = cc_high ? FCO_AUTOZERO : FCO_SAMPLE;
      nxt_az    = cc_high;
      nxt_sm    = !cc_high;
   end

   // Phase and indicator registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Idle clock is high, so reset lands in auto-zero
         phase_ff <= FCO_AUTOZERO;
         az_ff    <= 1'b1;
         sm_ff    <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         az_ff    <= nxt_az;
         sm_ff    <= nxt_sm;
      end
   end

   // Rising step: sampling at the last edge, high at this one
   assign rise = (phase_ff == FCO_SAMPLE) && cc_high;

   // ==========================================
   // Comparator latches
   // The latches follow the comparators on every edge that sees the
   // clock low, so the decision kept is the one from the last low
   // cycle. While the clock is high they freeze, which keeps the
   // encoder input steady across the load of the output latch.

   // Next latch contents
   always_comb begin
      if (cc_high) begin
         // Auto-zero: hold the last decisions
         nxt_latch = latch_ff;
      end else begin
         // Sampling: take the comparator pattern
         nxt_latch = cmp_therm;
      end
   end

   // Latch registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_ff <= '0;
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   // ==========================================
   // Thermometer encoder
   // The ones of the latched pattern are counted rather than looking
   // for the top set bit. A stray bubble in the pattern then moves the
   // code by one step instead of by a large jump.
   // Eight bits of count: all 128 tripped reads as 8'h80.
   assign acc[0] = 8'h00;
   genvar gi;
   generate
      for (gi = 0; gi < 128; gi++) begin : g_cnt
         // One adder stage per comparator
         assign acc[gi+1] = acc[gi] + {7'h00, latch_ff[gi]};
      end
   endgenerate
   assign ones = acc[128];

   // Count to straight binary code with over-range
   always_comb begin
      if (ones[7]) begin
         // Every comparator tripped: full scale or above
         enc_code = `FCO_CODE_TOP;
         enc_ovr  = 1'b1;
      end else begin
         // In range: the count is the code
         enc_code = ones[6:0];
         enc_ovr  = 1'b0;
      end
   end

   // ==========================================
   // Output latch
   // The encoder result is loaded once, at the edge that sees the
   // clock return high. Between two such edges the latch holds, so a
   // capture taken in the high interval after its first cycle reads one word.
   // Without a low interval in between nothing new is loaded.

   // Next output latch contents
   always_comb begin
      nxt_code = code_ff;
      nxt_ovr  = ovr_ff;
      if (rise) begin
         // Back to auto-zero: load the encoder result
         nxt_code = enc_code;
         nxt_ovr  = enc_ovr;
      end
   end

   // Output latch registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         code_ff <= `FCO_CODE_ZERO;
         ovr_ff  <= 1'b0;
      end else begin
         code_ff <= nxt_code;
         ovr_ff  <= nxt_ovr;
      end
   end

   // ==========================================
   // Output enables
   // The second select gates the whole output group; the first select
   // only takes the data bits off. Both enables are registered, so
   // they follow the selects one cycle later.

   // Next enable values from the selects
   always_comb begin
      nxt_ooe = pins.output_group_select;
      if (pins.output_group_select && !pins.data_bits_select) begin
         // Group on, data not held off
         nxt_doe = 1'b1;
      end else begin
         // Group off, or data held off by the first select
         nxt_doe = 1'b0;
      end
   end

   // Enable registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Reset floats every output
         doe_ff <= 1'b0;
         ooe_ff <= 1'b0;
      end else begin
         doe_ff <= nxt_doe;
         ooe_ff <= nxt_ooe;
      end
   end

   // ==========================================
   // Pin drive
   // Every pin and indicator comes straight from a register
   assign pins.data_o  = code_ff;
   assign pins.data_oe = doe_ff;
   assign pins.ovr_o   = ovr_ff;
   assign pins.ovr_oe  = ooe_ff;
   assign autozero_on  = az_ff;
   assign sample_on    = sm_ff;
endmodule : fco_device
`default_nettype wire

//--- design/fco_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "fco_defines.svh"
// ==========================================
// Capturing logic: makes conversion clock, selects, queues samples
module fco_host (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst,
   // Pins to converter
   fco_if.host                 pins,
   // User control
   input  wire logic           run,
   input  wire logic           data_bits_sel_in,
   input  wire logic [3:0]     high_cycles,
   // Sample stream
   output logic                smp_valid,
   input  wire logic           smp_ready,
   output logic [7:0]          smp_data,
   output logic                dropped
);
   import fco_pkg::*;

   fco_phase_t      phase_ff, nxt_phase;  // Clock level phase
   logic [3:0]      cnt_ff, nxt_cnt;      // Interval counter
   logic            cclk_ff, nxt_cclk;    // Conversion clock out
   logic            ds_ff, nxt_ds;        // First select out
   logic            gs_ff, nxt_gs;        // Second select out
   logic [1:0]      lat_ff, nxt_lat;      // Rising edges since run
   logic            cap_ff, nxt_cap;      // Capture strobe
   logic            drop_ff, nxt_drop;    // Overflow seen
   logic            ff_ready;             // FIFO room
   logic [3:0]      hi_len;               // High interval length
   fco_word_t       word;                 // Captured pins

   // Clock shaping and capture timing
   always_comb begin
      hi_len    = (high_cycles < 4'(`FCO_HIGH_CYC)) ? 4'(`FCO_HIGH_CYC) : high_cycles;
      nxt_phase = phase_ff;
      nxt_cnt   = cnt_ff;
      nxt_cclk  = cclk_ff;
      nxt_lat   = lat_ff;
      nxt_cap   = 1'b0;
      nxt_ds    = data_bits_sel_in;
      nxt_gs    = 1'b1;
      unique case (phase_ff)
         FCO_AUTOZERO: begin
            if (cnt_ff != 4'h0) begin
               nxt_cnt = cnt_ff - 4'h1;
            end else if (run) begin
               nxt_phase = FCO_SAMPLE;
               nxt_cclk  = 1'b0;
               nxt_cnt   = 4'(`FCO_LOW_CYC - 1);
            end
            // Result valid mid-high, one edge after the sampled low
            if (cnt_ff == 4'h0 && lat_ff == 2'd2) begin
               nxt_cap = 1'b1;
            end
         end
         FCO_SAMPLE: begin
            if (cnt_ff != 4'h0) begin
               nxt_cnt = cnt_ff - 4'h1;
            end else begin
               nxt_phase = FCO_AUTOZERO;
               nxt_cclk  = 1'b1;
               nxt_cnt   = hi_len - 4'h1;
               nxt_lat   = (lat_ff == 2'd2) ? 2'd2 : lat_ff + 2'd1;
            end
         end
         default: begin
            nxt_phase = FCO_AUTOZERO;
            nxt_cclk  = 1'b1;
         end
      endcase
      if (!run && phase_ff == FCO_AUTOZERO && cnt_ff == 4'h0) begin
         nxt_lat = (lat_ff == 2'd2) ? 2'd1 : lat_ff;
      end
      nxt_drop = cap_ff && !ff_ready;
   end

   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_ff <= FCO_AUTOZERO;
         cnt_ff   <= 4'h0;
         cclk_ff  <= 1'b1;
         ds_ff    <= 1'b0;
         gs_ff    <= 1'b0;
         lat_ff   <= 2'd0;
         cap_ff   <= 1'b0;
         drop_ff  <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         cnt_ff   <= nxt_cnt;
         cclk_ff  <= nxt_cclk;
         ds_ff    <= nxt_ds;
         gs_ff    <= nxt_gs;
         lat_ff   <= nxt_lat;
         cap_ff   <= nxt_cap;
         drop_ff  <= nxt_drop;
      end
   end

   assign pins.conv_clk            = cclk_ff;
   assign pins.data_bits_select    = ds_ff;
   assign pins.output_group_select = gs_ff;
   assign word.over_range = pins.ovr_oe  ? pins.ovr_o  : 1'b0;
   assign word.data       = pins.data_oe ? pins.data_o : 7'h00;
   assign dropped = drop_ff;

   // Sample queue
   fco_fifo #(.WIDTH(8), .DEPTH(`FCO_FIFO_DEPTH)) fco_fifo_i (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (cap_ff),
      .in_ready  (ff_ready),
      .in_data   (word),
      .out_valid (smp_valid),
      .out_ready (smp_ready),
      .out_data  (smp_data)
   );
endmodule : fco_host
`default_nettype wire

//--- tb/fco_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Pin rules watched between the two ends
module fco_chk (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Watched pins
   input  wire logic       conv_clk,
   input  wire logic       data_bits_select,
   input  wire logic       output_group_select,
   input  wire logic [6:0] data_o,
   input  wire logic       data_oe,
   input  wire logic       ovr_o,
   input  wire logic       ovr_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Whole output word as latched
   wire logic [7:0] word = {ovr_o, data_o};
   // ==========================================
   // Assertions
   a_data_oe_sel: assert property (data_oe == $past(output_group_select && !data_bits_select))
      else $error("data enable does not follow selects");
   a_ovr_oe_sel: assert property (ovr_oe == $past(output_group_select))
      else $error("over-range enable does not follow select");
   a_data_needs_grp: assert property (data_oe |-> ovr_oe)
      else $error("data driven without group select");
   a_ovr_full: assert property (ovr_o |-> data_o == 7'h7f)
      else $error("over-range without all ones");
   a_load_on_rise: assert property (!$stable(word) |->
      $past(conv_clk) && (!$past(conv_clk, 2) || !$past(conv_clk, 3)))
      else $error("latch changed away from a rising edge");
   a_hold_high: assert property (conv_clk && $past(conv_clk) && $past(conv_clk, 2)
      && $past(conv_clk, 3) |-> $stable(word))
      else $error("latch changed during long high");
   a_low_two: assert property ($fell(conv_clk) |=> !conv_clk ##1 conv_clk)
      else $error("low interval not two cycles");
   a_high_min: assert property ($rose(conv_clk) |-> conv_clk [*2])
      else $error("high interval shorter than two");
   // Main scenarios reached
   c_ovr: cover property (ovr_o && ovr_oe);
   c_data_off: cover property (ovr_oe && !data_oe);
   c_load: cover property (!$stable(word));
endmodule : fco_chk
`default_nettype wire

//--- tb/fco_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
// ==========================================
// Both ends joined, stream checked against therm input
module flash_adc_conversion_output_tb_top;
   import fco_pkg::*;
   logic         clk;
   logic         rst;
   logic         run;
   logic         dsel;              // Data bits select request
   logic         smp_ready;
   logic [3:0]   high_cycles;
   logic [127:0] cmp_therm;         // Comparator pattern
   wire logic    azo;
   wire logic    smo;
   wire logic    smp_valid;
   wire logic    dropped;
   wire logic [7:0] smp_data;
   int           checks = 0;
   int           miscompares = 0;
   int           seen = 0;          // Samples taken off the stream
   int           drops = 0;
   logic         prev_cc = 1'b1;
   logic [31:0]  rnd = 32'h86b0;
   logic [7:0]   exp_q[$];          // Expected words, oldest first
   int           ks[6] = '{0, 1, 63, 64, 127, 128};
   fco_if fco_if_i ();
   fco_device fco_device_i (.clk(clk), .rst(rst), .pins(fco_if_i), .cmp_therm(cmp_therm),
      .autozero_on(azo), .sample_on(smo));
   fco_host fco_host_i (.clk(clk), .rst(rst), .pins(fco_if_i), .run(run),
      .data_bits_sel_in(dsel), .high_cycles(high_cycles), .smp_valid(smp_valid),
      .smp_ready(smp_ready), .smp_data(smp_data), .dropped(dropped));
   fco_chk fco_chk_i (.clk(clk), .rst(rst), .conv_clk(fco_if_i.conv_clk),
      .data_bits_select(fco_if_i.data_bits_select),
      .output_group_select(fco_if_i.output_group_select), .data_o(fco_if_i.data_o),
      .data_oe(fco_if_i.data_oe), .ovr_o(fco_if_i.ovr_o), .ovr_oe(fco_if_i.ovr_oe));
   // Clock source
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Pseudo-random step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   // Waits for the stream to pass a sample count, bounded
   task automatic wait_seen(input int n);
      for (int i = 0; i < 600 && seen < n; i++) @(posedge clk);
      #1;
      // Limit ran out: stream stalled, count it
      if (seen < n) begin
         miscompares++;
         $display("[ERR] %0t stream stalled", $time);
      end
   endtask : wait_seen
   // Applies one input level, skips stale samples, then expects one word
   task automatic convert(input int k, input logic sel, input int skip);
      logic [7:0] e;
      cmp_therm = (k >= 128) ? '1 : ((128'h1 << k) - 128'h1);
      dsel = sel;
      high_cycles = rnd[3:0];
      rnd = xs(rnd);
      wait_seen(seen + skip);
      e = (k >= 128) ? 8'hff : {1'b0, 7'(k)};
      if (sel) begin
         e[6:0] = 7'h00;
      end
      exp_q.push_back(e);
      wait_seen(seen + 1);
   endtask : convert
   // Stream monitor and phase outputs
   always @(posedge clk) begin
      logic [7:0] e;
      if (!rst) begin
         `CHK(azo, prev_cc)
         `CHK(smo, ~prev_cc)
         if (dropped) begin
            drops++;
         end
         if (smp_valid && smp_ready) begin
            seen++;
            if (exp_q.size() > 0) begin
               e = exp_q.pop_front();
               `CHK(smp_data, e)
            end
         end
      end
      prev_cc = fco_if_i.conv_clk;
   end
   // Hang guard
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      run = 1'b0;
      dsel = 1'b0;
      smp_ready = 1'b1;
      high_cycles = 4'h0;
      cmp_therm = '0;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      run = 1'b1;
      foreach (ks[i]) convert(ks[i], 1'b0, 3);
      repeat (12) convert(int'(rnd % 129), rnd[9], 3);
      // Far side stalls: FIFO fills, captures are lost
      smp_ready = 1'b0;
      repeat (150) @(posedge clk);
      #1;
      `CHK(drops > 0, 1'b1)
      smp_ready = 1'b1;
      convert(100, 1'b0, 12);
      // Reset again in mid-run
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK({fco_if_i.data_oe, fco_if_i.ovr_oe, fco_if_i.data_o}, 9'h000)
      rst = 1'b0;
      convert(128, 1'b1, 3);
      convert(5, 1'b0, 3);
      end_sim();
   end
endmodule : flash_adc_conversion_output_tb_top
`default_nettype wire
